// *** hw/sep_pkg.sv ***
// Constants, opcodes, status layout and timing for the serial EEPROM
// command and protection block.
// Assumes a 100 MHz system clock and the smaller, 1024-byte array.
package sep_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_MS = 1000000;
    localparam int T_WRITE_CYCLE_MS = 5;
    // Longest time, so the division rounds down
    localparam int WRITE_CYCLE_CLKS =
        T_WRITE_CYCLE_MS * NS_PER_MS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_SET_WE = 8'h06;
    localparam logic [7:0] OP_CLR_WE = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_RD_ARRAY = 8'h03;
    localparam logic [7:0] OP_WR_ARRAY = 8'h02;

    // ------------------------------------------------------------------
    // Status byte layout and reset values
    // ------------------------------------------------------------------
    localparam int ST_PEN_BIT = 7;
    localparam int ST_BP_HI_BIT = 3;
    localparam int ST_BP_LO_BIT = 2;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam logic [1:0] BP_RESET = 2'h0;
    localparam logic PEN_RESET = 1'h0;

    // ------------------------------------------------------------------
    // Array geometry and protection ranges
    // ------------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int PAGE_IDX_W = 5;
    localparam logic [5:0] PAGE_BYTES = 6'h20;
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [ADDR_W-1:0] QUARTER_BASE = 10'h300;
    localparam logic [ADDR_W-1:0] HALF_BASE = 10'h200;

    // Transaction phases of the serial front end
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_OPCODE,
        PH_ADDR,
        PH_DATA,
        PH_STAT_IN,
        PH_STAT_OUT,
        PH_CLOSE,
        PH_IGNORE
    } sep_phase_type;

    // True when the block-protect setting covers the address
    function automatic logic sep_is_protected(input logic [1:0] bp,
                                              input logic [ADDR_W-1:0] a);
        case (bp)
            BP_NONE: return 1'b0;
            BP_QUARTER: return a >= QUARTER_BASE;
            BP_HALF: return a >= HALF_BASE;
            default: return 1'b1;
        endcase
    endfunction

endpackage

// *** hw/sep_pbuf_if.sv ***
// Connection between the command logic and its page load buffer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface sep_pbuf_if;
    import sep_pkg::*;
    logic wr_en;
    logic [PAGE_IDX_W-1:0] wr_idx;
    logic [7:0] wr_data;
    logic [PAGE_IDX_W-1:0] rd_idx;
    logic [7:0] rd_data;

    modport ctrl (output wr_en, output wr_idx, output wr_data,
                  output rd_idx, input rd_data);
    modport store (input wr_en, input wr_idx, input wr_data,
                   input rd_idx, output rd_data);
endinterface
`default_nettype wire

// *** hw/sep_page_buf.sv ***
// Page load buffer: 32 bytes of flip-flops, one write and one read port.
// Assumes the writer and the reader never need the same cycle ordering.
`timescale 1ns/1ps
`default_nettype none
module sep_page_buf
    import sep_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    sep_pbuf_if.store pb
);

    logic [7:0] mem_q [0:31];
    logic [7:0] mem_d [0:31];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Next contents: only the addressed byte changes
    always_comb begin
        mem_d = mem_q;
        if (pb.wr_en) begin
            mem_d[pb.wr_idx] = pb.wr_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 32; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else begin
            mem_q <= mem_d;
        end
    end

    // Read is combinational; the caller registers it
    assign pb.rd_data = mem_q[pb.rd_idx];

endmodule // sep_page_buf
`default_nettype wire

// *** hw/sep_core.sv ***
// Serial command, status and write-protection logic of a small EEPROM.
// Assumes the serial pins come from an outside host and are sampled
// by clk_sys, which must be well above twice the serial clock rate.
`timescale 1ns/1ps
`default_nettype none
module sep_core
    import sep_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLE_CLKS
)(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic chip_sel_b,
    input wire logic ser_clk,
    input wire logic ser_in,
    input wire logic pause_b,
    input wire logic wr_protect_b,
    output logic ser_out,
    output logic ser_out_oe,
    output logic busy,
    output logic prog_wr,
    output logic [ADDR_W-1:0] prog_addr,
    output logic [7:0] prog_data
);

    localparam logic [31:0] WC_LAST = 32'(WRITE_CYCLES - 1);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Order: protect, pause, data in, clock, select
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    logic sck_last_q;
    logic cs_last_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_q <= 5'h1D;
            pin_sync_q <= 5'h1D;
            sck_last_q <= 1'b0;
            cs_last_q <= 1'b1;
        end else begin
            pin_meta_q <= {wr_protect_b, pause_b, ser_in, ser_clk,
                           chip_sel_b};
            pin_sync_q <= pin_meta_q;
            sck_last_q <= pin_sync_q[1];
            cs_last_q <= pin_sync_q[0];
        end
    end

    logic cs_s, sck_s, si_s, pause_s, wp_s;
    logic active, sck_rise, sck_fall, cs_rise;
    assign {wp_s, pause_s, si_s, sck_s, cs_s} = pin_sync_q;
    // Edges seen during a pause are dropped, so input changes are lost
    assign active = !cs_s && pause_s;
    assign sck_rise = active && sck_s && !sck_last_q;
    assign sck_fall = active && !sck_s && sck_last_q;
    assign cs_rise = cs_s && !cs_last_q;

    // ------------------------------------------------------------------
    // Page buffer
    // ------------------------------------------------------------------
    sep_pbuf_if pbuf ();

    sep_page_buf u_page_buf (
        .clk_sys (clk_sys),
        .rst_b (rst_b),
        .pb (pbuf.store)
    );

    // ------------------------------------------------------------------
    // Command and write-cycle state
    // ------------------------------------------------------------------
    sep_phase_type phase_q, phase_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] op_q, op_d;
    logic addr_byte_q, addr_byte_d;
    logic [15:0] addr_q, addr_d;
    logic [PAGE_IDX_W-1:0] page_idx_q, page_idx_d;
    logic [5:0] data_bytes_q, data_bytes_d;
    logic [31:0] loaded_q, loaded_d;
    logic wr_ok_q, wr_ok_d;
    logic wp_low_seen_q, wp_low_seen_d;
    logic [7:0] out_shift_q, out_shift_d;
    logic so_q, so_d;
    logic wel_q, wel_d;
    logic [1:0] bp_q, bp_d;
    logic pen_q, pen_d;
    logic busy_q, busy_d;
    logic wc_status_q, wc_status_d;
    logic [7:0] pend_stat_q, pend_stat_d;
    logic [31:0] timer_q, timer_d;
    logic [5:0] sweep_q, sweep_d;
    logic prog_wr_q, prog_wr_d;
    logic [ADDR_W-1:0] prog_addr_q, prog_addr_d;
    logic [7:0] prog_data_q, prog_data_d;

    logic [7:0] status;
    logic [7:0] in_byte;
    logic [15:0] addr_next;
    logic stat_writable;

    // Unused bits 6..4 read as zero
    always_comb begin
        status = 8'h00;
        status[ST_PEN_BIT] = pen_q;
        status[ST_BP_HI_BIT] = bp_q[1];
        status[ST_BP_LO_BIT] = bp_q[0];
        status[ST_WEL_BIT] = wel_q;
        status[ST_BUSY_BIT] = busy_q;
    end

    assign in_byte = {shift_q[6:0], si_s};
    assign addr_next = {addr_q[14:0], si_s};
    // A protect pin that went low at any unpaused point in the frame counts
    assign stat_writable = wel_q && (!pen_q || !wp_low_seen_q);

    // Next-state logic for the serial front end and the write cycle
    always_comb begin
        phase_d = phase_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        op_d = op_q;
        addr_byte_d = addr_byte_q;
        addr_d = addr_q;
        page_idx_d = page_idx_q;
        data_bytes_d = data_bytes_q;
        loaded_d = loaded_q;
        wr_ok_d = wr_ok_q;
        wp_low_seen_d = wp_low_seen_q || (active && !wp_s);
        out_shift_d = out_shift_q;
        so_d = so_q;
        wel_d = wel_q;
        bp_d = bp_q;
        pen_d = pen_q;
        busy_d = busy_q;
        wc_status_d = wc_status_q;
        pend_stat_d = pend_stat_q;
        timer_d = timer_q;
        sweep_d = sweep_q;
        prog_wr_d = 1'b0;
        prog_addr_d = prog_addr_q;
        prog_data_d = prog_data_q;
        pbuf.wr_en = 1'b0;
        pbuf.wr_idx = page_idx_q;
        pbuf.wr_data = in_byte;
        pbuf.rd_idx = sweep_q[PAGE_IDX_W-1:0];

        // Serial front end
        if (cs_s) begin
            phase_d = PH_IDLE;
            if (cs_rise) begin
                // Closing edge: enable latch and write starts
                if (phase_q == PH_CLOSE && op_q == OP_SET_WE) begin
                    wel_d = 1'b1;
                end
                if (phase_q == PH_CLOSE && op_q == OP_WR_STATUS &&
                    stat_writable) begin
                    busy_d = 1'b1;
                    wc_status_d = 1'b1;
                    pend_stat_d = shift_q;
                    timer_d = 32'h0;
                end
                // Only whole data bytes into an open range start a write
                if (phase_q == PH_DATA && bit_cnt_q == 3'h0 &&
                    data_bytes_q != 6'h00 && wr_ok_q) begin
                    busy_d = 1'b1;
                    wc_status_d = 1'b0;
                    timer_d = 32'h0;
                    sweep_d = 6'h00;
                end
            end
        end else begin
            case (phase_q)
                PH_IDLE: begin
                    phase_d = PH_OPCODE;
                    bit_cnt_d = 3'h0;
                    wp_low_seen_d = !wp_s;
                end
                PH_OPCODE: begin
                    if (sck_rise) begin
                        shift_d = in_byte;
                        bit_cnt_d = bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            op_d = in_byte;
                            phase_d = PH_IGNORE;
                            if (busy_q && in_byte != OP_RD_STATUS) begin
                                phase_d = PH_IGNORE;
                            end else begin
                                case (in_byte)
                                    OP_SET_WE: phase_d = PH_CLOSE;
                                    OP_CLR_WE: wel_d = 1'b0;
                                    OP_RD_STATUS: phase_d = PH_STAT_OUT;
                                    OP_WR_STATUS: phase_d = PH_STAT_IN;
                                    OP_WR_ARRAY: begin
                                        phase_d = PH_ADDR;
                                        addr_byte_d = 1'b0;
                                        data_bytes_d = 6'h00;
                                        loaded_d = 32'h0;
                                    end
                                    default: phase_d = PH_IGNORE;
                                endcase
                            end
                        end
                    end
                end
                PH_ADDR: begin
                    if (sck_rise) begin
                        addr_d = addr_next;
                        bit_cnt_d = bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            addr_byte_d = 1'b1;
                            if (addr_byte_q) begin
                                phase_d = PH_DATA;
                                page_idx_d = addr_next[PAGE_IDX_W-1:0];
                                // Upper address bits are don't care
                                wr_ok_d = wel_q && !sep_is_protected(bp_q,
                                    addr_next[ADDR_W-1:0]);
                            end
                        end
                    end
                end
                PH_DATA: begin
                    if (sck_rise) begin
                        shift_d = in_byte;
                        bit_cnt_d = bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            // Index wraps inside the page, page bits fixed
                            pbuf.wr_en = 1'b1;
                            loaded_d[page_idx_q] = 1'b1;
                            page_idx_d = page_idx_q + 5'h01;
                            if (data_bytes_q != PAGE_BYTES) begin
                                data_bytes_d = data_bytes_q + 6'h01;
                            end
                        end
                    end
                end
                PH_STAT_IN: begin
                    if (sck_rise) begin
                        shift_d = in_byte;
                        bit_cnt_d = bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h7) begin
                            phase_d = PH_CLOSE;
                        end
                    end
                end
                PH_STAT_OUT: begin
                    // Fresh status each byte so busy polling sees changes
                    if (sck_fall) begin
                        bit_cnt_d = bit_cnt_q + 3'h1;
                        if (bit_cnt_q == 3'h0) begin
                            so_d = status[7];
                            out_shift_d = {status[6:0], 1'b0};
                        end else begin
                            so_d = out_shift_q[7];
                            out_shift_d = {out_shift_q[6:0], 1'b0};
                        end
                    end
                end
                PH_CLOSE: begin
                    // Extra clocks after the command void it
                    if (sck_rise) begin
                        phase_d = PH_IGNORE;
                    end
                end
                default: phase_d = PH_IGNORE;
            endcase
        end

        // Internal write cycle: drain the page, then wait out the time
        if (busy_q) begin
            timer_d = timer_q + 32'h1;
            if (!wc_status_q && sweep_q != PAGE_BYTES) begin
                prog_wr_d = loaded_q[sweep_q[PAGE_IDX_W-1:0]];
                prog_addr_d = {addr_q[ADDR_W-1:PAGE_IDX_W],
                               sweep_q[PAGE_IDX_W-1:0]};
                prog_data_d = pbuf.rd_data;
                sweep_d = sweep_q + 6'h01;
            end
            if (timer_q == WC_LAST) begin
                busy_d = 1'b0;
                wel_d = 1'b0;
                if (wc_status_q) begin
                    pen_d = pend_stat_q[ST_PEN_BIT];
                    bp_d = {pend_stat_q[ST_BP_HI_BIT],
                            pend_stat_q[ST_BP_LO_BIT]};
                end
            end
        end
    end

    // Registers; power-up leaves the latch cleared
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= PH_IDLE;
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            op_q <= 8'h00;
            addr_byte_q <= 1'b0;
            addr_q <= 16'h0000;
            page_idx_q <= 5'h00;
            data_bytes_q <= 6'h00;
            loaded_q <= 32'h0;
            wr_ok_q <= 1'b0;
            wp_low_seen_q <= 1'b0;
            out_shift_q <= 8'h00;
            so_q <= 1'b0;
            wel_q <= 1'b0;
            bp_q <= BP_RESET;
            pen_q <= PEN_RESET;
            busy_q <= 1'b0;
            wc_status_q <= 1'b0;
            pend_stat_q <= 8'h00;
            timer_q <= 32'h0;
            sweep_q <= 6'h00;
            prog_wr_q <= 1'b0;
            prog_addr_q <= '0;
            prog_data_q <= 8'h00;
        end else begin
            phase_q <= phase_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            op_q <= op_d;
            addr_byte_q <= addr_byte_d;
            addr_q <= addr_d;
            page_idx_q <= page_idx_d;
            data_bytes_q <= data_bytes_d;
            loaded_q <= loaded_d;
            wr_ok_q <= wr_ok_d;
            wp_low_seen_q <= wp_low_seen_d;
            out_shift_q <= out_shift_d;
            so_q <= so_d;
            wel_q <= wel_d;
            bp_q <= bp_d;
            pen_q <= pen_d;
            busy_q <= busy_d;
            wc_status_q <= wc_status_d;
            pend_stat_q <= pend_stat_d;
            timer_q <= timer_d;
            sweep_q <= sweep_d;
            prog_wr_q <= prog_wr_d;
            prog_addr_q <= prog_addr_d;
            prog_data_q <= prog_data_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Driven only in the status read phase, never while paused
    assign ser_out_oe = active && phase_q == PH_STAT_OUT;
    assign ser_out = so_q;
    assign busy = busy_q;
    assign prog_wr = prog_wr_q;
    assign prog_addr = prog_addr_q;
    assign prog_data = prog_data_q;

endmodule // sep_core
`default_nettype wire

// *** tb/sep_host_model.sv ***
// Host SPI controller model: select, clock, data and pause pins.
// Assumes a 125 ns link clock; the bench calls xfer by hierarchy.
`timescale 1ns/1ps
`default_nettype none
module sep_host_model (
    output var logic chip_sel_b,
    output var logic ser_clk,
    output var logic ser_in,
    output var logic pause_b,
    input wire logic ser_out,
    input wire logic ser_out_oe
);
    logic [7:0] rx;
    logic saw_oe;
    initial {chip_sel_b, ser_clk, ser_in, pause_b} = 4'h9;
    // Data set while clock low, device takes it at the rise
    task automatic bit_out(input logic b);
        ser_clk = 1'b0;
        ser_in = b;
        #62.5 ser_clk = 1'b1;
        // Raw OR so an unknown enable cannot pass as silent
        saw_oe |= ser_out_oe;
        rx = {rx[6:0], ser_out};
        #62.5;
    endtask
    // Opcode then n bits MSB first; a pause goes before bit pz
    task automatic xfer(input logic [7:0] op, input int n,
        input logic [279:0] d, input int pz, input logic cpol);
        saw_oe = 1'b0;
        ser_clk = cpol;
        #62.5 chip_sel_b = 1'b0;
        for (int i = n + 7; i >= 0; i--) begin
            if (i == pz) begin
                // Clock low at both pause edges; junk edges between
                ser_clk = 1'b0;
                #62.5 pause_b = 1'b0;
                repeat (4) #62.5 {ser_clk, ser_in} = ~{ser_clk, ser_in};
                #62.5 pause_b = 1'b1;
            end
            bit_out(i >= n ? op[i - n] : d[i]);
        end
        ser_clk = cpol;
        #62.5 chip_sel_b = 1'b1;
        // Released data line must not keep its last value
        ser_in = ~ser_in;
        #200;
    endtask
endmodule // sep_host_model
`default_nettype wire

// *** tb/sep_core_assertions.sv ***
// Port-level checker of the serial EEPROM command block, bound below.
// Assumes pins are slow against clk_sys (about three cycles of sync).
`timescale 1ns/1ps
`default_nettype none
module sep_core_assertions
    import sep_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLE_CLKS
)(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic chip_sel_b,
    input wire logic ser_clk,
    input wire logic pause_b,
    input wire logic ser_out,
    input wire logic ser_out_oe,
    input wire logic busy,
    input wire logic prog_wr,
    input wire logic [ADDR_W-1:0] prog_addr
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    // Busy cycles so far; a counter avoids a huge repetition
    always_comb cnt_d = busy ? cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) cnt_q <= 32'h0;
        else cnt_q <= cnt_d;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence sel_idle; chip_sel_b [*4]; endsequence
    sequence held_pause; !pause_b [*4]; endsequence
    oe_idle_a: assert property (sel_idle |-> !ser_out_oe)
        else $error("output driven while deselected");
    oe_pause_a: assert property (held_pause |-> !ser_out_oe)
        else $error("output driven while paused");
    out_fall_a: assert property (ser_out_oe && $changed(ser_out)
        |-> !ser_clk) else $error("output moved with clock high");
    prog_busy_a: assert property (prog_wr |-> busy && cnt_q <= 32'h21)
        else $error("program pulse outside write window");
    page_fix_a: assert property (prog_wr && $past(prog_wr) |->
        prog_addr[9:5] == $past(prog_addr[9:5])
        && prog_addr[4:0] > $past(prog_addr[4:0])) else $error("page moved");
    busy_max_a: assert property (busy |-> cnt_q < WRITE_CYCLES)
        else $error("write cycle too long");
    busy_min_a: assert property ($fell(busy) |->
        cnt_q >= WRITE_CYCLES - 1) else $error("write cycle too short");
    busy_start_a: assert property ($rose(busy) |->
        chip_sel_b && $past(chip_sel_b)) else $error("busy while selected");
endmodule // sep_core_assertions
bind sep_core sep_core_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .chip_sel_b(chip_sel_b),
    .ser_clk(ser_clk), .pause_b(pause_b), .ser_out(ser_out),
    .ser_out_oe(ser_out_oe), .busy(busy), .prog_wr(prog_wr),
    .prog_addr(prog_addr));
`default_nettype wire

// *** tb/sep_core_tb.sv ***
// Self-checking bench of the serial EEPROM command block.
// Assumes the host model owns the serial pins; bench drives reset, WP.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module sep_core_tb;
    import sep_pkg::*;
    // Short write cycle, still long enough to poll status while busy
    localparam int WC = 400;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic wr_protect_b = 1'b1;
    logic chip_sel_b, ser_clk, ser_in, pause_b, ser_out, ser_out_oe;
    logic busy, prog_wr;
    logic [ADDR_W-1:0] prog_addr;
    logic [7:0] prog_data, st, op;
    logic [17:0] seen[$];
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 32'hFD4D;
    always #5 clk_sys = ~clk_sys;
    sep_core #(.WRITE_CYCLES(WC)) uut (.clk_sys(clk_sys), .rst_b(rst_b),
        .chip_sel_b(chip_sel_b), .ser_clk(ser_clk), .ser_in(ser_in),
        .pause_b(pause_b), .wr_protect_b(wr_protect_b), .ser_out(ser_out),
        .ser_out_oe(ser_out_oe), .busy(busy), .prog_wr(prog_wr),
        .prog_addr(prog_addr), .prog_data(prog_data));
    sep_host_model host (.chip_sel_b(chip_sel_b), .ser_clk(ser_clk),
        .ser_in(ser_in), .pause_b(pause_b), .ser_out(ser_out),
        .ser_out_oe(ser_out_oe));
    // Log programmed bytes in the order the design emits them; the falling
    // edge keeps clear of the edge that launches each pulse
    always @(negedge clk_sys)
        if (prog_wr === 1'b1) seen.push_back({prog_addr, prog_data});
    function automatic logic prot(logic [1:0] bp, logic [9:0] a);
        return bp == 2'h3 || (bp == 2'h2 && a[9]) || (bp == 2'h1 && &a[9:8]);
    endfunction
    task automatic cmd(input logic [7:0] c);
        host.xfer(c, 0, '0, -1, 1'b0);
    endtask
    task automatic rd_st(input logic [7:0] e);
        host.xfer(OP_RD_STATUS, 8, '0, -1, 1'b0);
        `CHK("status", e, host.rx)
        `CHK("oe on", 1'b1, host.saw_oe)
    endtask
    task automatic idle;
        for (int i = 0; i < WC + 50 && busy !== 1'b0; i++) @(negedge clk_sys);
        `CHK("busy end", 1'b0, busy)
    endtask
    // Page load of n random bytes at a; acc tells if it may program
    task automatic pg_wr(input logic [15:0] a, input int n, input logic acc);
        logic [279:0] d;
        logic [7:0] e[32];
        logic v[32];
        int k;
        d = 280'(a);
        v = '{default: 1'b0};
        for (int i = 0; i < n; i++) begin
            d = {d[271:0], 8'($random(seed))};
            k = (int'(a[4:0]) + i) % 32;
            e[k] = d[7:0];
            v[k] = acc;
        end
        seen.delete();
        cmd(OP_SET_WE);
        host.xfer(OP_WR_ARRAY, 16 + 8 * n, d, -1, 1'b0);
        `CHK("busy start", acc, busy)
        if (acc) cmd(OP_CLR_WE);
        if (acc) rd_st(st | 8'h03);
        idle();
        for (k = 0; k < 32; k++)
            if (v[k]) `CHK("prog", {a[9:5], 5'(k), e[k]}, seen.pop_front())
        `CHK("prog count", 0, seen.size())
        rd_st(st | {6'h0, !acc, 1'b0});
    endtask
    // Status write; wpm 1 drops the protect pin in-frame, 2 after start
    task automatic write_status_cmd(input logic [7:0] s, input int wpm, input logic acc);
        cmd(OP_SET_WE);
        fork
            host.xfer(OP_WR_STATUS, 8, 280'(s), -1, 1'b0);
            if (wpm == 1) #1300 @(negedge clk_sys) wr_protect_b = 1'b0;
        join
        `CHK("status busy", acc, busy)
        if (wpm == 2) @(negedge clk_sys) wr_protect_b = 1'b0;
        idle();
        @(negedge clk_sys) wr_protect_b = 1'b1;
        if (acc) st = s & 8'h8C;
        rd_st(st | {6'h0, !acc, 1'b0});
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        st = 8'h00;
        repeat (6) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (4) @(negedge clk_sys);
        rd_st(8'h00);
        cmd(OP_SET_WE);
        rd_st(8'h02);
        cmd(OP_CLR_WE);
        rd_st(8'h00);
        host.xfer(OP_SET_WE, 1, '0, -1, 1'b0);
        rd_st(8'h00);
        host.xfer(OP_SET_WE, 0, '0, -1, 1'b1);
        host.xfer(OP_RD_STATUS, 8, '0, -1, 1'b1);
        `CHK("mode 11", 8'h02, host.rx)
        // Unknown patterns: no output, latch left alone
        repeat (12) begin
            do op = 8'($random(seed));
            while (op inside {[8'h01:8'h06]});
            host.xfer(op, 16, 280'($random(seed)), -1, 1'b0);
            `CHK("silent", 1'b0, host.saw_oe)
        end
        rd_st(8'h02);
        $display("done: commands");
        host.xfer(OP_WR_ARRAY, 28, 280'($random(seed)), -1, 1'b0);
        `CHK("part byte", 1'b0, busy)
        cmd(OP_CLR_WE);
        host.xfer(OP_WR_ARRAY, 24, 280'($random(seed)), -1, 1'b0);
        `CHK("no latch", 1'b0, busy)
        pg_wr(16'($random(seed)), 33, 1'b1);
        pg_wr(16'($random(seed)), 1 + ($random(seed) & 31), 1'b1);
        $display("done: page");
        write_status_cmd(8'hFF, 0, 1'b1);
        for (int b = 0; b < 4; b++) begin
            write_status_cmd(8'(b << 2), 0, 1'b1);
            for (int j = 0; j < 4; j++) begin
                // Either side of the half and then the quarter boundary
                op = (j > 1) ? 8'h40 : 8'h00;
                pg_wr({6'($random(seed)), 10'h1FF + 10'(j & 1) + {op, 2'h0}},
                    1, !prot(2'(b), 10'h1FF + 10'(j & 1) + {op, 2'h0}));
            end
        end
        write_status_cmd(8'h80, 0, 1'b1);
        write_status_cmd(8'h84, 1, 1'b0);
        write_status_cmd(8'h84, 2, 1'b1);
        $display("done: protect");
        cmd(OP_SET_WE);
        host.xfer(OP_RD_STATUS, 8, '0, 3, 1'b0);
        `CHK("paused read", 8'h86, host.rx)
        $display("done: pause");
        test_done();
    end
    // Watchdog well past the expected run length
    initial begin
        #600000;
        num_errors++;
        test_done();
    end
endmodule // sep_core_tb
`default_nettype wire
